// File: hw/pta_arbiter.sv
// Two-level bus arbiter with timeout, parking, lock and register slave.
`timescale 1ns/10ps
`default_nettype none

module pta_arbiter
  import pta_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Avalon-MM register slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Bus pins, all active low.
  input wire logic [7:0] req_n,
  input wire logic frame_n,
  input wire logic lock_n,
  input wire logic flush_ack_n,
  output logic [7:0] gnt_n,
  output logic flush_req_n
);

  // ==========================================================================
  // Pin synchronisers
  logic [7:0] req_m_q, req_s_q;
  logic [2:0] pin_m_q, pin_s_q;
  logic [7:0] req_act;
  logic frame_act, lock_act, ack_act;

  // Two flops per pin; only the second stage feeds logic.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      req_m_q <= 8'hFF;
      req_s_q <= 8'hFF;
      pin_m_q <= 3'h7;
      pin_s_q <= 3'h7;
    end else begin
      req_m_q <= req_n;
      req_s_q <= req_m_q;
      pin_m_q <= {frame_n, lock_n, flush_ack_n};
      pin_s_q <= pin_m_q;
    end
  end

  assign req_act = ~req_s_q;
  assign frame_act = ~pin_s_q[2];
  assign lock_act = ~pin_s_q[1];
  assign ack_act = ~pin_s_q[0];

  // ==========================================================================
  // Register slave
  logic [7:0] pri1_q, pri1_d, prix_q, prix_d, slot_q, slot_d, ctrl_q, ctrl_d;
  logic [31:0] rd_q, rd_d;
  logic wr_q, wr_d;
  logic [7:0] stat;

  // Register state, readable for software.
  pta_state_t st_q, st_d;
  logic [2:0] own_q, own_d;
  logic locked_q, locked_d;
  logic flush_q, flush_d;
  assign stat = {st_q, locked_q, own_q};

  // Waitrequest drops the cycle after a request; writes land on the edge that raises it again.
  always_comb begin
    pri1_d = pri1_q;
    prix_d = prix_q;
    slot_d = slot_q;
    ctrl_d = ctrl_q;
    rd_d = rd_q;
    wr_d = 1'b1;
    if ((avs_read || avs_write) && wr_q) begin
      wr_d = 1'b0;
      // Only reads load the data flop, so read data hold until the next read.
      if (avs_read) begin
        case (avs_address)
          OFS_PRI1: rd_d = {PAD_ZERO, pri1_q};
          OFS_PRIX: rd_d = {PAD_ZERO, prix_q};
          OFS_SLOT: rd_d = {PAD_ZERO, slot_q};
          OFS_CTRL: rd_d = {PAD_ZERO, ctrl_q};
          OFS_STAT: rd_d = {PAD_ZERO, stat};
          default: rd_d = 32'h00000000;
        endcase
      end
    end
    if (avs_write && !wr_q && avs_byteenable[0]) begin
      case (avs_address)
        OFS_PRI1: pri1_d = avs_writedata[7:0];
        OFS_PRIX: prix_d = avs_writedata[7:0] & MSK_PRIX;
        OFS_SLOT: slot_d = avs_writedata[7:0];
        OFS_CTRL: ctrl_d = avs_writedata[7:0] & MSK_CTRL;
        default: ctrl_d = ctrl_q;
      endcase
    end
  end

  // Register storage with the documented reset values.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pri1_q <= RST_PRI1;
      prix_q <= RST_PRIX;
      slot_q <= RST_SLOT;
      ctrl_q <= RST_CTRL;
      rd_q <= 32'h00000000;
      wr_q <= 1'b1;
    end else begin
      pri1_q <= pri1_d;
      prix_q <= prix_d;
      slot_q <= slot_d;
      ctrl_q <= ctrl_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
    end
  end

  assign avs_readdata = rd_q;
  assign avs_waitrequest = wr_q;

  // ==========================================================================
  // Level one: three rotating pairs and the fixed bank 0
  logic [7:0] excl_q, excl_d, req_eff;
  logic [3:0] bank_v;
  logic [3:0] bank_side;
  logic tk;
  logic [2:0] tk_idx;

  // A master that just timed out sits out one arbitration round.
  assign req_eff = req_act & ~excl_q;

  // Bank 0 never rotates: the disk port always beats agent e.
  assign bank_side[0] = ~req_eff[RQ_DISK];
  assign bank_v[0] = req_eff[RQ_DISK] | req_eff[RQ_E];

  for (genvar b = 1; b < 4; b++) begin : g_bank
    assign bank_v[b] = req_eff[2*b] | req_eff[2*b+1];
    pta_pair u_pair (
      .clk(clk),
      .resetn(resetn),
      .agent_a_request(req_eff[2*b]),
      .agent_b_request(req_eff[2*b+1]),
      .fix(pri1_q[PRI1_FIX_LO+b-1]),
      .rot(pri1_q[PRI1_ROT_LO+b-1]),
      .take(tk && (tk_idx[2:1] == 2'(b))),
      .take_side(tk_idx[0]),
      .win_side(bank_side[b])
    );
  end

  // ==========================================================================
  // Level two: cyclic bank order picked by scheme, slot round-robin
  logic [2:0] rr_q, rr_d;
  logic [1:0] scheme, win_bank;
  logic [2:0] win_idx;
  logic [7:0] sup_hit;

  // Slots 0..3 carry schemes 0..3; slots 4..7 take the programmed fields.
  always_comb begin
    if (!prix_q[PRIX_ROT]) begin
      scheme = pri1_q[PRI1_FP_LO +: 2];
    end else if (!rr_q[2]) begin
      scheme = rr_q[1:0];
    end else begin
      scheme = slot_q[2*rr_q[1:0] +: 2];
    end
  end

  // First valid bank in the order starting at the scheme's head.
  always_comb begin
    logic [1:0] k;
    k = 2'h0;
    win_bank = scheme;
    for (int i = 3; i >= 0; i--) begin
      k = scheme + 2'(i);
      if (bank_v[k]) begin
        win_bank = k;
      end
    end
  end

  // The super agent, when requesting, overrides the whole tree.
  assign sup_hit = pta_sup_mask(prix_q[PRIX_SUP_LO +: 3]) & req_eff;
  always_comb begin
    win_idx = {win_bank, bank_side[win_bank]};
    for (int i = 0; i < 8; i++) begin
      if (sup_hit[i]) begin
        win_idx = 3'(i);
      end
    end
  end

  // ==========================================================================
  // Grant sequencer
  logic [7:0] gnt_q, gnt_d;
  logic [2:0] last_q, last_d, pend_q, pend_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] park_idx;

  // Idle parking target.
  assign park_idx = ctrl_q[CTRL_PARK] ? last_q : RQ_HOST;

  // Grant, flush handshake, frame wait with timeout and owned-bus tracking.
  always_comb begin
    st_d = st_q;
    gnt_d = gnt_q;
    own_d = own_q;
    last_d = last_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    excl_d = excl_q;
    flush_d = flush_q;
    locked_d = locked_q;
    rr_d = rr_q;
    tk = 1'b0;
    tk_idx = win_idx;
    case (st_q)
      ST_ARB: begin
        if (|req_eff) begin
          if (ctrl_q[CTRL_GAT] && (win_idx != RQ_HOST)) begin
            // Host caches flush before another master gets the bus.
            st_d = ST_FLUSH;
            pend_d = win_idx;
            flush_d = 1'b1;
            gnt_d = 8'h00;
          end else begin
            tk = 1'b1;
          end
        end else begin
          excl_d = 8'h00;
          gnt_d = pta_onehot(park_idx);
        end
      end
      ST_FLUSH: begin
        tk_idx = pend_q;
        if (ack_act) begin
          flush_d = 1'b0;
          tk = 1'b1;
        end
      end
      ST_WAIT: begin
        if (frame_act) begin
          st_d = ST_OWN;
        end else if (!req_act[own_q]) begin
          st_d = ST_ARB;
          gnt_d = 8'h00;
        end else if (ctrl_q[CTRL_TOEN] &&
                     (cnt_q == pta_to_limit(ctrl_q[CTRL_TO_LO +: 2]) - CNT_ONE)) begin
          st_d = ST_ARB;
          gnt_d = 8'h00;
          excl_d = pta_onehot(own_q);
        end else begin
          cnt_d = cnt_q + CNT_ONE;
        end
      end
      ST_OWN: begin
        if (ctrl_q[CTRL_LOCK] && lock_act && frame_act) begin
          locked_d = 1'b1;
        end
        if (!frame_act && !(locked_q && lock_act)) begin
          // Unlocked bus ends here; a held lock keeps the grant on the owner.
          locked_d = 1'b0;
          st_d = ST_ARB;
          gnt_d = 8'h00;
        end
      end
      default: begin
        st_d = ST_ARB;
        gnt_d = 8'h00;
      end
    endcase
    if (tk) begin
      st_d = ST_WAIT;
      gnt_d = pta_onehot(tk_idx);
      own_d = tk_idx;
      last_d = tk_idx;
      cnt_d = 6'h00;
      excl_d = 8'h00;
      if (prix_q[PRIX_ROT]) begin
        rr_d = rr_q + 3'h1;
      end
    end
  end

  // Sequencer registers; grants come straight from flops.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ST_ARB;
      gnt_q <= 8'h00;
      own_q <= RQ_HOST;
      last_q <= RQ_HOST;
      pend_q <= RQ_HOST;
      cnt_q <= 6'h00;
      excl_q <= 8'h00;
      flush_q <= 1'b0;
      locked_q <= 1'b0;
      rr_q <= 3'h0;
    end else begin
      st_q <= st_d;
      gnt_q <= gnt_d;
      own_q <= own_d;
      last_q <= last_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      excl_q <= excl_d;
      flush_q <= flush_d;
      locked_q <= locked_d;
      rr_q <= rr_d;
    end
  end

  assign gnt_n = ~gnt_q;
  assign flush_req_n = ~flush_q;

endmodule // pta_arbiter

`default_nettype wire

// File: hw/pta_pkg.sv
// Package of constants, types and helpers for the two-level bus arbiter.
package pta_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFS_PRI1 = 8'h00;
  localparam logic [7:0] OFS_PRIX = 8'h04;
  localparam logic [7:0] OFS_SLOT = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // ==========================================================================
  // Reset values and writable-bit masks
  localparam logic [7:0] RST_PRI1 = 8'hE0;
  localparam logic [7:0] RST_PRIX = 8'h01;
  localparam logic [7:0] RST_SLOT = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h80;
  localparam logic [7:0] MSK_PRIX = 8'h0F;
  localparam logic [7:0] MSK_CTRL = 8'h9F;
  localparam logic [23:0] PAD_ZERO = 24'h000000;

  // ==========================================================================
  // Field positions
  localparam int PRI1_ROT_LO = 5;
  localparam int PRI1_FP_LO = 3;
  localparam int PRI1_FIX_LO = 0;
  localparam int PRIX_SUP_LO = 1;
  localparam int PRIX_ROT = 0;
  localparam int CTRL_GAT = 7;
  localparam int CTRL_TO_LO = 3;
  localparam int CTRL_TOEN = 2;
  localparam int CTRL_PARK = 1;
  localparam int CTRL_LOCK = 0;

  // ==========================================================================
  // Requester indices: bit 0 is the side within a bank, bits 2:1 the bank.
  localparam logic [2:0] RQ_DISK = 3'h0;
  localparam logic [2:0] RQ_E = 3'h1;
  localparam logic [2:0] RQ_BRIDGE = 3'h2;
  localparam logic [2:0] RQ_A = 3'h3;
  localparam logic [2:0] RQ_B = 3'h4;
  localparam logic [2:0] RQ_C = 3'h5;
  localparam logic [2:0] RQ_HOST = 3'h6;
  localparam logic [2:0] RQ_D = 3'h7;

  // ==========================================================================
  // Grant-to-frame timeout lengths in clocks
  localparam logic [5:0] TO_CLK_0 = 6'h10;
  localparam logic [5:0] TO_CLK_1 = 6'h04;
  localparam logic [5:0] TO_CLK_2 = 6'h08;
  localparam logic [5:0] TO_CLK_3 = 6'h20;
  localparam logic [5:0] CNT_ONE = 6'h01;

  // ==========================================================================
  // Arbiter states, one-hot.
  typedef enum logic [3:0] {
    ST_ARB = 4'h1,
    ST_FLUSH = 4'h2,
    ST_WAIT = 4'h4,
    ST_OWN = 4'h8
  } pta_state_t;

  // Timeout code to clock count.
  function automatic logic [5:0] pta_to_limit(input logic [1:0] code);
    case (code)
      2'h0: pta_to_limit = TO_CLK_0;
      2'h1: pta_to_limit = TO_CLK_1;
      2'h2: pta_to_limit = TO_CLK_2;
      default: pta_to_limit = TO_CLK_3;
    endcase
  endfunction

  // Super-agent code to a one-hot requester mask; zero when disabled.
  function automatic logic [7:0] pta_sup_mask(input logic [2:0] code);
    logic [7:0] m;
    m = 8'h00;
    case (code)
      3'h1: m[RQ_DISK] = 1'b1;
      3'h2: m[RQ_BRIDGE] = 1'b1;
      3'h3: m[RQ_HOST] = 1'b1;
      3'h4: m[RQ_A] = 1'b1;
      3'h5: m[RQ_B] = 1'b1;
      3'h6: m[RQ_C] = 1'b1;
      3'h7: m[RQ_D] = 1'b1;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  // Index to one-hot vector.
  function automatic logic [7:0] pta_onehot(input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    v[idx] = 1'b1;
    return v;
  endfunction

endpackage

// File: hw/pta_pair.sv
// Level-one pair arbiter: picks one side of a requester pair.
`timescale 1ns/10ps
`default_nettype none

module pta_pair
  import pta_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Requests, side 0 is the first-listed line.
  input wire logic agent_a_request,
  input wire logic agent_b_request,
  // Configuration.
  input wire logic fix,
  input wire logic rot,
  // Grant notice from the arbiter core.
  input wire logic take,
  input wire logic take_side,
  // Result.
  output logic win_side
);

  logic hi_q;
  logic hi_d;
  logic eff_hi;

  // Leading side: fixed order, or the rotating pointer when rotation is on.
  assign eff_hi = rot ? hi_q : fix;
  assign win_side = (agent_a_request && agent_b_request) ? eff_hi : agent_b_request;

  // Rotation steps only when the leading side was granted.
  always_comb begin
    hi_d = hi_q;
    if (!rot) begin
      hi_d = fix;
    end else if (take && (take_side == eff_hi)) begin
      hi_d = ~eff_hi;
    end
  end

  // Pointer register.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hi_q <= 1'b0;
    end else begin
      hi_q <= hi_d;
    end
  end

endmodule // pta_pair

`default_nettype wire

// File: verif/pta_assertions.sv
// Port checker of the two-level bus arbiter, bound to its top module.
`timescale 1ns/10ps
`default_nettype none

module pta_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic resetn,
  // Register bus.
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Bus pins.
  input wire logic frame_n,
  input wire logic flush_ack_n,
  input wire logic lock_n,
  input wire logic [7:0] gnt_n,
  input wire logic flush_req_n
);
  // ==========================================================================
  // Common clocking
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // A granted master has driven its frame for three cycles.
  sequence own_s;
    (gnt_n != 8'hFF && !frame_n) [*3];
  endsequence

  // ==========================================================================
  // Register bus
  chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("register access not answered");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_read_pad: assert property (avs_readdata[31:8] == 24'h000000)
    else $error("readdata upper bits set");
  chk_read_hold: assert property ($changed(avs_readdata) |-> !avs_waitrequest && $past(avs_read))
    else $error("readdata changed without a read");

  // ==========================================================================
  // Grants
  // Reset must win over everything, so this one is never disabled.
  chk_reset_idle: assert property (disable iff (1'b0)
    !resetn |=> gnt_n == 8'hFF && flush_req_n && avs_waitrequest)
    else $error("outputs not idle after reset");
  chk_one_grant: assert property ($countones(~gnt_n) <= 1)
    else $error("more than one grant");
  chk_flush_first: assert property (!flush_req_n && flush_ack_n |=> (gnt_n | 8'h40) == 8'hFF)
    else $error("grant before flush acknowledge");
  chk_ack_grant: assert property ($fell(flush_ack_n) && !flush_req_n |->
    ##[1:5] (gnt_n[6] && gnt_n != 8'hFF))
    else $error("no grant after flush acknowledge");
  chk_frame_hold: assert property (own_s ##1 !frame_n |-> $stable(gnt_n))
    else $error("grant moved during frame");
  // A held lock keeps the grant on its owner, so only unlocked frames must free the bus.
  chk_frame_gap: assert property (own_s ##1 ($rose(frame_n) && lock_n) |-> ##[1:3] gnt_n == 8'hFF)
    else $error("no idle grant cycle after frame");
endmodule // pta_checker

bind pta_arbiter pta_checker u_chk (.clk(clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .frame_n(frame_n), .flush_ack_n(flush_ack_n), .lock_n(lock_n), .gnt_n(gnt_n),
  .flush_req_n(flush_req_n));

`default_nettype wire

// File: verif/pta_masters.sv
// Behavioural bus masters and flush responder facing the arbiter.
`timescale 1ns/10ps
`default_nettype none

module pta_masters (
  // Clock, reset and bench commands.
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] want,
  input wire logic go,
  input wire logic lk,
  // Arbiter pins.
  input wire logic [7:0] gnt_n,
  input wire logic flush_req_n,
  output logic [7:0] req_n,
  output logic frame_n,
  output logic lock_n,
  output logic flush_ack_n
);
  logic [7:0] done;
  logic [3:0] fcnt;
  logic [1:0] acnt;

  // Frame is driven four cycles; the pulled-up line idles high between frames.
  assign frame_n = !(fcnt != 4'h0 && fcnt < 4'h5);
  assign lock_n = !lk;

  // A master that ended its frame keeps its request off until the bench clears it.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      done <= 8'h00;
      fcnt <= 4'h0;
      acnt <= 2'h0;
      req_n <= 8'hFF;
      flush_ack_n <= 1'b1;
    end else begin
      done <= (done | (fcnt == 4'h4 ? ~gnt_n : 8'h00)) & want;
      req_n <= ~(want & ~done);
      fcnt <= (fcnt != 4'h0) ? fcnt + 4'h1 : {3'h0, go && (~gnt_n & ~req_n) != 8'h00};
      acnt <= flush_req_n ? 2'h0 : acnt + {1'b0, acnt != 2'h3};
      flush_ack_n <= flush_req_n | (acnt < 2'h2);
    end
  end
endmodule // pta_masters

`default_nettype wire

// File: verif/pta_arbiter_bench.sv
// Self-checking bench of the two-level bus arbiter.
`timescale 1ns/10ps
`default_nettype none

module pta_arbiter_bench;
  import pta_pkg::*;
  logic clk, resetn, avs_read, avs_write, avs_waitrequest, go, lk;
  logic frame_n, lock_n, flush_ack_n, flush_req_n;
  logic [7:0] avs_address, req_n, gnt_n, want, q;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  int fails = 0;
  int n_tests = 0;

  // ==========================================================================
  // Design and masters
  pta_arbiter dut (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .req_n(req_n), .frame_n(frame_n), .lock_n(lock_n),
    .flush_ack_n(flush_ack_n), .gnt_n(gnt_n), .flush_req_n(flush_req_n));
  pta_masters u_mst (.clk(clk), .resetn(resetn), .want(want), .go(go), .lk(lk), .gnt_n(gnt_n),
    .flush_req_n(flush_req_n), .req_n(req_n), .frame_n(frame_n), .lock_n(lock_n),
    .flush_ack_n(flush_ack_n));

  // Clock at 250 MHz.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    // A transfer that never completes counts as a mismatch.
    chk({7'h00, avs_waitrequest}, 8'h00);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(q, e);
  endtask

  // Grant latency varies with synchronisers and flush, so wait with a bound.
  task automatic wg(input logic [7:0] e);
    int k;
    k = 0;
    while (gnt_n !== e && k < 80) begin
      @(posedge clk);
      k++;
    end
    chk(gnt_n, e);
  endtask

  task automatic tally_and_finish;
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rd(OFS_PRI1, 8'hE0);
    rd(OFS_PRIX, 8'h01);
    rd(OFS_SLOT, 8'h00);
    rd(OFS_CTRL, 8'h80);
    bus(1'b1, OFS_PRIX, 8'hFF);
    rd(OFS_PRIX, 8'h0F);
    bus(1'b1, OFS_SLOT, 8'hA5);
    rd(OFS_SLOT, 8'hA5);
    avs_byteenable <= 4'h0;
    bus(1'b1, OFS_SLOT, 8'h5A);
    avs_byteenable <= 4'h1;
    rd(OFS_SLOT, 8'hA5);
    rd(8'h14, 8'h00);
    bus(1'b1, OFS_PRIX, 8'h00);
  endtask

  task automatic t_flush;
    int k;
    k = 0;
    wg(8'hBF);
    want <= 8'h08;
    while (flush_req_n !== 1'b0 && k < 20) begin
      @(posedge clk);
      k++;
    end
    chk({6'h00, gnt_n[3], flush_req_n}, 8'h02);
    wg(8'hF7);
    want <= 8'h00;
    wg(8'hBF);
    bus(1'b1, OFS_CTRL, 8'h00);
  endtask

  // Parking on the last master keeps every expected grant apart from the parked one.
  task automatic t_order;
    bus(1'b1, OFS_CTRL, 8'h02);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, OFS_PRI1, 8'(s << 3));
      want <= 8'h55;
      wg(~(8'h01 << (2 * s)));
      want <= 8'h00;
      wg(8'hFF);
    end
    for (int k = 1; k < 4; k++) begin
      for (int f = 0; f < 2; f++) begin
        bus(1'b1, OFS_PRI1, 8'((k << 3) | (f << (k - 1))));
        want <= 8'(3 << (2 * k));
        wg(~(8'h01 << (2 * k + f)));
        want <= 8'h00;
        wg(8'hFF);
      end
    end
    bus(1'b1, OFS_PRI1, 8'h07);
    want <= 8'h03;
    wg(8'hFE);
    want <= 8'h00;
    wg(8'hFF);
  endtask

  task automatic t_super;
    logic [2:0] idx[7] = '{3'h0, 3'h2, 3'h6, 3'h3, 3'h4, 3'h5, 3'h7};
    bus(1'b1, OFS_PRI1, 8'h00);
    for (int c = 7; c > 0; c--) begin
      bus(1'b1, OFS_PRIX, 8'(c << 1));
      want <= 8'hFF;
      wg(~(8'h01 << idx[c - 1]));
      want <= 8'h00;
      wg(8'hFF);
    end
    bus(1'b1, OFS_PRIX, 8'h00);
  endtask

  task automatic t_timeout;
    int lim[4] = '{16, 4, 8, 32};
    int k;
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, OFS_CTRL, 8'(4 | (c << 3)));
      want <= 8'h18;
      wg(8'hF7);
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (gnt_n[3] === 1'b0 && k < 60);
      chk(8'(k), 8'(lim[c]));
      wg(8'hEF);
      want <= 8'h00;
      wg(8'hBF);
    end
    bus(1'b1, OFS_CTRL, 8'h00);
    want <= 8'h08;
    wg(8'hF7);
    repeat (40) @(posedge clk);
    chk(gnt_n, 8'hF7);
    want <= 8'h00;
    wg(8'hBF);
  endtask

  task automatic t_frame;
    bus(1'b1, OFS_CTRL, 8'h02);
    go <= 1'b1;
    want <= 8'h10;
    wg(8'hEF);
    wg(8'hFF);
    repeat (3) @(posedge clk);
    chk(gnt_n, 8'hEF);
    go <= 1'b0;
    want <= 8'h00;
  endtask

  // Lock held through a frame: ignored when disabled, keeps the grant when enabled.
  task automatic t_lock;
    lk <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      repeat (20) @(posedge clk);
      bus(1'b1, OFS_CTRL, 8'(2 + e));
      go <= 1'b1;
      want <= 8'h10;
      repeat (20) @(posedge clk);
      rd(OFS_STAT, e ? 8'h8C : 8'h14);
      chk(gnt_n, 8'hEF);
      if (e == 1) begin
        lk <= 1'b0;
        wg(8'hFF);
      end
      go <= 1'b0;
      want <= 8'h00;
    end
  endtask

  // Bank 1 rotation: the leader alternates after each grant to it.
  task automatic t_rotate;
    bus(1'b1, OFS_PRI1, 8'h28);
    for (int n = 0; n < 3; n++) begin
      want <= 8'h0C;
      wg(n == 1 ? 8'hF7 : 8'hFB);
      want <= 8'h00;
      wg(8'hFF);
    end
  endtask

  // Level-two slot round-robin: four fixed schemes, then the programmed slot fields.
  task automatic t_slots;
    logic [1:0] sch[8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h1, 2'h3};
    bus(1'b1, OFS_PRI1, 8'h00);
    bus(1'b1, OFS_SLOT, 8'hD8);
    bus(1'b1, OFS_PRIX, 8'h01);
    for (int n = 0; n < 8; n++) begin
      want <= 8'h55;
      wg(~(8'h01 << (2 * sch[n])));
      want <= 8'h00;
      wg(8'hFF);
    end
    bus(1'b1, OFS_PRIX, 8'h00);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    resetn = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h1;
    want = 8'h00;
    go = 1'b0;
    lk = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_flush;
    t_order;
    t_super;
    t_timeout;
    t_frame;
    t_lock;
    t_rotate;
    t_slots;
    tally_and_finish;
  end

  // A hang counts as a mismatch and closes the run.
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    tally_and_finish;
  end
endmodule // pta_arbiter_bench

`default_nettype wire
